/* File: sbc_pkg.sv */
// shared constants and carrier types for the six-bit binary codec
package sbc_pkg;
  localparam logic [7:0] SBC_ASCII_ZERO = 8'h30;
  localparam logic [7:0] SBC_ASCII_TOP = 8'h6F;
  localparam logic [7:0] SBC_ASCII_TWO_TOP = 8'h33;
  localparam logic [2:0] SBC_CHARS_PER_GROUP = 3'h6;
  localparam logic [1:0] SBC_BYTES_PER_GROUP_M1 = 2'h3;
  localparam logic [15:0] SBC_HDR_OPC_2D = 16'h0093;
  localparam logic [15:0] SBC_HDR_OPC_3D = 16'h0094;
  localparam logic [15:0] SBC_BIN_DATA_OPC = 16'h010A;
  localparam logic [15:0] SBC_END_LIST_OPC = 16'h006B;
  localparam logic [15:0] SBC_END_LIST_LEN = 16'h0002;
  localparam logic [15:0] SBC_PKT_OVERHEAD = 16'h0004;
  localparam logic [15:0] SBC_BN_EXTRA = 16'h0002;
  localparam logic [7:0] SBC_TYPE_DOTS = 8'h01;
  localparam logic [7:0] SBC_TYPE_CONN = 8'h03;
  localparam logic [7:0] SBC_TYPE_SEP = 8'h04;

  typedef enum logic [1:0] {SBC_LIST_DOTS, SBC_LIST_CONNECTED, SBC_LIST_SEPARATE} sbc_list_kind_t;

  // description of one vector-list packet as the host side wants it
  typedef struct packed {
    sbc_list_kind_t kind;
    logic dim_3d;
    logic block_norm;
    logic [15:0] vector_count;
  } sbc_frame_cfg_t;

  // framing words that go into the message, binary lengths only
  typedef struct packed {
    logic [15:0] header_opcode;
    logic [7:0] list_type;
    logic [15:0] total_count;
    logic [15:0] binary_opcode;
    logic [15:0] data_count;
    logic [15:0] end_length;
    logic [15:0] end_opcode;
  } sbc_frame_info_t;
endpackage : sbc_pkg

/* File: sbc_codec.sv */
// six-bit printable codec: word encoder, character decoder, list framing fields
// Functional notes
// RULE1: encode only after two 16-bit words held
// RULE2: group splits into five six-bit, one two-bit
// RULE3: fields taken from least significant end upward
// RULE4: send two-bit character first, reverse extraction order
// RULE5: add ASCII zero to every character
// RULE6: host sends each word MSB first
// RULE7: store word MSB at lower address
// RULE8: byte counts exclude six-bit expansion bytes
// RULE9: host encodes data before sending count
// RULE10: host suppresses carriage control in binary
// RULE11: header opcode 147 for 2D, 148 3D
// RULE12: list type 1 dots, 3 connected, 4 separate
// RULE13: vector normalized total and opcode 266
// RULE14: block normalized count is count*2*dim+2
// RULE15: list closed by length 2, opcode 107
// RULE16: decoder subtracts zero, reassembles words inversely
// RULE17: host sends only complete vectors per packet
`timescale 1ns/1ps
`default_nettype none
module sbc_codec
  import sbc_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // binary words to encode
  input wire logic [15:0] enc_word_i,
  input wire logic enc_word_valid_i,
  output logic enc_word_ready_o,
  // printable characters out
  output logic [7:0] enc_char_o,
  output logic enc_char_valid_o,
  input wire logic enc_char_ready_i,
  // printable characters in
  input wire logic [7:0] dec_char_i,
  input wire logic dec_char_valid_i,
  output logic dec_char_ready_o,
  // decoded group and byte store
  output logic [31:0] dec_group_o,
  output logic dec_group_valid_o,
  output logic dec_char_err_o,
  input wire logic dec_addr_clear_i,
  output logic [ADDR_W-1:0] mem_addr_o,
  output logic [7:0] mem_byte_o,
  output logic mem_we_o,
  // list framing
  input wire sbc_frame_cfg_t frame_cfg_i,
  output sbc_frame_info_t frame_info_o
);

  // ---------------- encoder ----------------
  logic have_first, next_have_first;
  logic [15:0] first_word, next_first_word;
  logic [31:0] enc_sr, next_enc_sr;
  logic [2:0] enc_left, next_enc_left;
  logic [7:0] enc_char, next_enc_char;
  logic word_take, char_take, enc_load;

  assign enc_word_ready_o = (enc_left == 3'h0);
  assign word_take = enc_word_valid_i && enc_word_ready_o;
  assign enc_load = word_take && have_first;
  assign char_take = enc_char_valid_o && enc_char_ready_i;
  assign enc_char_valid_o = (enc_left != 3'h0);
  assign enc_char_o = enc_char;

  // the earlier word becomes the upper half; the two-bit field leaves first
  always_comb begin
    next_have_first = have_first;
    next_first_word = first_word;
    next_enc_sr = enc_sr;
    next_enc_left = enc_left;
    next_enc_char = enc_char;
    if (word_take && !have_first) begin
      next_have_first = 1'b1; // [RULE1]
      next_first_word = enc_word_i;
    end else if (enc_load) begin
      next_have_first = 1'b0;
      next_enc_sr = {first_word[13:0], enc_word_i, 2'h0}; // [RULE3]
      next_enc_left = SBC_CHARS_PER_GROUP; // [RULE1] [RULE2]
      next_enc_char = SBC_ASCII_ZERO + {6'h00, first_word[15:14]}; // [RULE4] [RULE5]
    end else if (char_take) begin
      next_enc_left = enc_left - 3'h1;
      next_enc_char = SBC_ASCII_ZERO + {2'h0, enc_sr[31:26]}; // [RULE4] [RULE5]
      next_enc_sr = {enc_sr[25:0], 6'h00};
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      have_first <= 1'b0;
      first_word <= 16'h0000;
      enc_sr <= 32'h0000_0000;
      enc_left <= 3'h0;
      enc_char <= 8'h00;
    end else begin
      have_first <= next_have_first;
      first_word <= next_first_word;
      enc_sr <= next_enc_sr;
      enc_left <= next_enc_left;
      enc_char <= next_enc_char;
    end
  end

  // ---------------- decoder ----------------
  typedef enum logic {SBC_DEC_GATHER, SBC_DEC_STORE} sbc_dec_state_t;
  sbc_dec_state_t dec_state, next_dec_state;
  logic [2:0] dec_cnt, next_dec_cnt;
  logic [31:0] dec_sr, next_dec_sr;
  logic [1:0] byte_idx, next_byte_idx;
  logic [ADDR_W-1:0] addr, next_addr;
  logic [7:0] mem_byte, next_mem_byte;
  logic mem_we, next_mem_we, grp_valid, next_grp_valid, char_err, next_char_err;
  logic dec_take;
  logic [7:0] payload;

  // out-of-range characters are flagged but still consumed, so framing never stalls
  function automatic logic char_bad(input logic [7:0] c, input logic first);
    char_bad = (c < SBC_ASCII_ZERO) || (c > (first ? SBC_ASCII_TWO_TOP : SBC_ASCII_TOP));
  endfunction : char_bad

  assign dec_char_ready_o = (dec_state == SBC_DEC_GATHER);
  assign dec_take = dec_char_valid_i && dec_char_ready_o;
  assign payload = dec_char_i - SBC_ASCII_ZERO; // [RULE16]

  // gather six characters, then write the group out byte by byte
  always_comb begin
    next_dec_state = dec_state;
    next_dec_cnt = dec_cnt;
    next_dec_sr = dec_sr;
    next_byte_idx = byte_idx;
    next_addr = addr;
    next_mem_byte = mem_byte;
    next_mem_we = 1'b0;
    next_grp_valid = 1'b0;
    next_char_err = 1'b0;
    unique case (dec_state)
      SBC_DEC_GATHER: begin
        if (dec_take) begin
          next_char_err = char_bad(dec_char_i, dec_cnt == 3'h0);
          if (dec_cnt == 3'h0) begin
            next_dec_sr = {30'h0000_0000, payload[1:0]}; // [RULE16]
          end else begin
            next_dec_sr = {dec_sr[25:0], payload[5:0]}; // [RULE16]
          end
          if (dec_cnt == SBC_CHARS_PER_GROUP - 3'h1) begin
            next_dec_cnt = 3'h0;
            next_grp_valid = 1'b1;
            next_byte_idx = 2'h0;
            next_dec_state = SBC_DEC_STORE;
          end else begin
            next_dec_cnt = dec_cnt + 3'h1;
          end
        end
      end
      SBC_DEC_STORE: begin
        // high byte of each word goes to the lower address
        next_mem_we = 1'b1; // [RULE7]
        next_mem_byte = dec_sr[8'(31 - 8 * byte_idx) -: 8]; // [RULE7]
        if (mem_we) begin
          next_addr = addr + ADDR_W'(1);
        end
        next_byte_idx = byte_idx + 2'h1;
        if (byte_idx == SBC_BYTES_PER_GROUP_M1) begin
          next_dec_state = SBC_DEC_GATHER;
        end
      end
    endcase
    if (mem_we && dec_state == SBC_DEC_GATHER) begin
      next_addr = addr + ADDR_W'(1);
    end
    if (dec_addr_clear_i) begin
      next_addr = '0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      dec_state <= SBC_DEC_GATHER;
      dec_cnt <= 3'h0;
      dec_sr <= 32'h0000_0000;
      byte_idx <= 2'h0;
      addr <= '0;
      mem_byte <= 8'h00;
      mem_we <= 1'b0;
      grp_valid <= 1'b0;
      char_err <= 1'b0;
    end else begin
      dec_state <= next_dec_state;
      dec_cnt <= next_dec_cnt;
      dec_sr <= next_dec_sr;
      byte_idx <= next_byte_idx;
      addr <= next_addr;
      mem_byte <= next_mem_byte;
      mem_we <= next_mem_we;
      grp_valid <= next_grp_valid;
      char_err <= next_char_err;
    end
  end

  assign dec_group_o = dec_sr;
  assign dec_group_valid_o = grp_valid;
  assign dec_char_err_o = char_err;
  assign mem_addr_o = addr;
  assign mem_byte_o = mem_byte;
  assign mem_we_o = mem_we;

  // ---------------- framing fields ----------------
  sbc_frame_info_t info, next_info;
  logic [15:0] dim, data_len;

  // counts are binary lengths; the six-bit expansion is never counted
  always_comb begin
    dim = frame_cfg_i.dim_3d ? 16'h0003 : 16'h0002;
    if (frame_cfg_i.block_norm) begin
      data_len = 16'(frame_cfg_i.vector_count * 16'h0002 * dim) + SBC_BN_EXTRA; // [RULE14] [RULE8]
    end else begin
      data_len = 16'(frame_cfg_i.vector_count * (dim + 16'h0001) * 16'h0002); // [RULE13] [RULE8]
    end
    next_info.header_opcode = frame_cfg_i.dim_3d ? SBC_HDR_OPC_3D : SBC_HDR_OPC_2D; // [RULE11]
    unique case (frame_cfg_i.kind)
      SBC_LIST_DOTS: next_info.list_type = SBC_TYPE_DOTS; // [RULE12]
      SBC_LIST_CONNECTED: next_info.list_type = SBC_TYPE_CONN;
      SBC_LIST_SEPARATE: next_info.list_type = SBC_TYPE_SEP;
      default: next_info.list_type = SBC_TYPE_CONN; // unused code folds to connected
    endcase
    next_info.total_count = SBC_PKT_OVERHEAD + data_len; // [RULE13]
    next_info.binary_opcode = SBC_BIN_DATA_OPC; // [RULE13]
    next_info.data_count = data_len;
    next_info.end_length = SBC_END_LIST_LEN; // [RULE15]
    next_info.end_opcode = SBC_END_LIST_OPC; // [RULE15]
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      info <= '0;
    end else begin
      info <= next_info;
    end
  end

  assign frame_info_o = info;

  // ---------------- checks ----------------
  enc_pair_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RULE1]
    $rose(enc_char_valid_o) |-> $past(word_take && have_first))
    else $error("encoder started without a full word pair");
  enc_six_chars_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RULE2]
    enc_load ##1 (enc_char_ready_i && enc_char_valid_o) [*6] |=> !enc_char_valid_o)
    else $error("group did not yield exactly six characters");
  enc_two_bit_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RULE4]
    enc_load |=> enc_char_o == SBC_ASCII_ZERO + {6'h00, $past(first_word[15:14])})
    else $error("first character is not the two-bit field");
  enc_low_last_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RULE3]
    enc_load ##1 (enc_char_ready_i && enc_char_valid_o) [*5]
      |=> enc_char_o == SBC_ASCII_ZERO + {2'h0, $past(enc_word_i[5:0], 6)})
    else $error("last character is not bits 5 to 0");
  enc_printable_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RULE5]
    enc_char_valid_o |-> (enc_char_o >= SBC_ASCII_ZERO && enc_char_o <= SBC_ASCII_TOP))
    else $error("encoded character not offset by ASCII zero");
  dec_msb_low_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RULE7]
    $rose(mem_we_o) |-> mem_byte_o == dec_sr[31:24] ##1 mem_byte_o == dec_sr[23:16])
    else $error("word high byte not stored first");
  dec_group_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RULE16]
    dec_take && dec_cnt == 3'h5 |=> dec_group_o[5:0] == 6'($past(payload)) ##1 mem_we_o)
    else $error("decoded group not reassembled");
  frm_opcode_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RULE11]
    $past(frame_cfg_i.dim_3d) |-> frame_info_o.header_opcode == 16'd148)
    else $error("3D header opcode wrong");
  // the word registered during reset is all zero, so the first cycle after release is skipped
  frm_total_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RULE13]
    $past(rst_n_i) |-> (frame_info_o.total_count == frame_info_o.data_count + 16'h0004 &&
      frame_info_o.binary_opcode == 16'h010A))
    else $error("packet total count or data opcode wrong");
  frm_type_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RULE12]
    $past(frame_cfg_i.kind) == SBC_LIST_SEPARATE |-> frame_info_o.list_type == 8'd4)
    else $error("separate list type code wrong");

endmodule : sbc_codec
`default_nettype wire

/* File: sbc_host_model.sv */
// host-side model: encodes one 32-bit group and sends six printable characters
`timescale 1ns/1ps
`default_nettype none
module sbc_host_model
  import sbc_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // commands from the bench
  input wire logic send_i,
  input wire logic bad_i,
  input wire logic gap_i,
  input wire logic [31:0] group_i,
  // character stream toward the decoder
  output logic [7:0] char_o,
  output logic valid_o,
  input wire logic ready_i
);
  logic [31:0] grp;
  logic [2:0] idx;
  logic busy;

  // character k of a group, first word in the upper half, two-bit field first
  function automatic logic [7:0] enc(input logic [31:0] g, input logic [2:0] k);
    if (k == 3'h0) begin
      return {6'h00, g[31:30]} + 8'h30;
    end
    return {2'h0, g[35-6*k -: 6]} + 8'h30;
  endfunction : enc

  // only encoded characters go out, never line control; bad_i raises the first one by 4
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      valid_o <= 1'b0;
      busy <= 1'b0;
      idx <= 3'h0;
      grp <= 32'h0;
      char_o <= 8'hA5;
    end else if (!busy && send_i) begin
      busy <= 1'b1;
      valid_o <= 1'b1;
      idx <= 3'h0;
      grp <= group_i;
      char_o <= enc(group_i, 3'h0) + (bad_i ? 8'h04 : 8'h00); // fault only on command
    end else if (valid_o && ready_i) begin
      if (idx == 3'h5) begin
        busy <= 1'b0;
        valid_o <= 1'b0;
        char_o <= ~char_o; // released line must not keep the last value
      end else if (gap_i) begin
        valid_o <= 1'b0;
        idx <= idx + 3'h1;
        char_o <= ~char_o;
      end else begin
        idx <= idx + 3'h1;
        char_o <= enc(grp, idx + 3'h1);
      end
    end else if (busy && !valid_o) begin
      valid_o <= 1'b1;
      char_o <= enc(grp, idx);
    end
  end
endmodule : sbc_host_model
`default_nettype wire

/* File: tb.sv */
// self-checking bench for the six-bit codec
`timescale 1ns/1ps
`default_nettype none
module tb
  import sbc_pkg::*;
;
  typedef struct packed {logic [31:0] grp; logic [47:0] chars;} sbc_row_t;
  logic ref_clk_i, rst_n_i, enc_word_valid_i, enc_char_ready_i, dec_addr_clear_i;
  logic [15:0] enc_word_i;
  logic enc_word_ready_o, enc_char_valid_o, dec_char_ready_o, dec_group_valid_o;
  logic dec_char_err_o, mem_we_o, dec_char_valid_i, send, bad, gap;
  logic [7:0] enc_char_o, dec_char_i, mem_byte_o;
  logic [31:0] dec_group_o, hgrp;
  logic [15:0] mem_addr_o;
  sbc_frame_cfg_t frame_cfg_i;
  sbc_frame_info_t frame_info_o, fexp;
  int mismatches, check_count, dim, data;
  sbc_row_t rows [4] = '{'{32'h40004000, "100400"}, '{32'hFFFFFFFF, "3ooooo"},
                         '{32'h00000000, "000000"}, '{32'h12345678, "0B=5Ih"}};

  sbc_codec uut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .enc_word_i(enc_word_i),
    .enc_word_valid_i(enc_word_valid_i), .enc_word_ready_o(enc_word_ready_o),
    .enc_char_o(enc_char_o), .enc_char_valid_o(enc_char_valid_o),
    .enc_char_ready_i(enc_char_ready_i), .dec_char_i(dec_char_i),
    .dec_char_valid_i(dec_char_valid_i), .dec_char_ready_o(dec_char_ready_o),
    .dec_group_o(dec_group_o), .dec_group_valid_o(dec_group_valid_o),
    .dec_char_err_o(dec_char_err_o), .dec_addr_clear_i(dec_addr_clear_i),
    .mem_addr_o(mem_addr_o), .mem_byte_o(mem_byte_o), .mem_we_o(mem_we_o),
    .frame_cfg_i(frame_cfg_i), .frame_info_o(frame_info_o));
  sbc_host_model host (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .send_i(send), .bad_i(bad),
    .gap_i(gap), .group_i(hgrp), .char_o(dec_char_i), .valid_o(dec_char_valid_i),
    .ready_i(dec_char_ready_o));

  // 25 MHz clock
  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end

  task summarize;
    if (mismatches == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize

  task chk_val(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk_val

  task chk_frame(input sbc_frame_info_t got, input sbc_frame_info_t exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t framing %h expected %h", $time, got, exp);
    end
  endtask : chk_frame

  // a wait that runs out ends the run as a failure
  task automatic wait_hi(ref logic sig);
    int n;
    n = 0;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (sig !== 1'b1 && n < 60);
    if (sig !== 1'b1) begin
      mismatches++;
      summarize();
    end
  endtask : wait_hi

  task send_word(input logic [15:0] w);
    enc_word_i <= w;
    enc_word_valid_i <= 1'b1;
    wait_hi(enc_word_ready_o);
    enc_word_valid_i <= 1'b0;
  endtask : send_word

  // takes six characters; a stall holds ready low first so the char must stand
  task recv(input logic [47:0] exp, input bit stall);
    int k, n;
    k = 0;
    n = 0;
    enc_char_ready_i <= !stall;
    while (k < 6 && n < 60) begin
      @(posedge ref_clk_i);
      n++;
      if (enc_char_valid_o === 1'b1) begin
        chk_val(enc_word_ready_o, 0);
        if (enc_char_ready_i) begin
          chk_val(enc_char_o, exp[47-8*k -: 8]);
          k++;
        end else if (n > 5) enc_char_ready_i <= 1'b1;
      end
    end
    chk_val(k, 6);
  endtask : recv

  // partner sends the group, decoder must rebuild it and store bytes MSB first
  task check_dec(input logic [31:0] g, input logic [15:0] base);
    hgrp <= g;
    send <= 1'b1;
    @(posedge ref_clk_i);
    send <= 1'b0;
    wait_hi(dec_group_valid_o);
    chk_val(dec_group_o, g);
    for (int b = 0; b < 4; b++) begin
      wait_hi(mem_we_o);
      chk_val(mem_addr_o, base + 16'(b));
      chk_val(mem_byte_o, g[31-8*b -: 8]);
    end
  endtask : check_dec

  initial begin
    {rst_n_i, enc_word_valid_i, enc_char_ready_i, send, bad, gap} = '0;
    {enc_word_i, hgrp, frame_cfg_i} = '0;
    dec_addr_clear_i = 1'b1;
    mismatches = 0;
    check_count = 0;
    repeat (12) @(posedge ref_clk_i);
    chk_val({enc_word_ready_o, dec_char_ready_o, enc_char_valid_o, mem_we_o}, 32'hC);
    rst_n_i <= 1'b1;
    dec_addr_clear_i <= 1'b0;
    @(posedge ref_clk_i);
    // table rows: encode, then decode through the host model; encode stalls on row 1, decode gaps on odd rows
    for (int i = 0; i < 4; i++) begin
      send_word(rows[i].grp[31:16]);
      repeat (3) @(posedge ref_clk_i);
      chk_val(enc_char_valid_o, 0);
      send_word(rows[i].grp[15:0]);
      recv(rows[i].chars, i == 1);
      gap <= i[0];
      check_dec(rows[i].grp, 16'(4 * i));
    end
    // framing words for every list kind, the unused kind code, dimension and normalisation
    // whole vector counts only, so every packet carries complete vectors
    for (int k = 0; k < 4; k++) begin
      for (int m = 0; m < 4; m++) begin
        frame_cfg_i <= '{sbc_list_kind_t'(k), m[0], m[1], 16'h0005};
        repeat (2) @(posedge ref_clk_i);
        dim = m[0] ? 3 : 2;
        data = m[1] ? 5 * 2 * dim + 2 : 5 * (dim + 1) * 2;
        fexp = '{m[0] ? 16'h0094 : 16'h0093, k == 0 ? 8'h01 : (k == 2 ? 8'h04 : 8'h03),
                 16'(data + 4), 16'h010A, 16'(data), 16'h0002, 16'h006B};
        chk_frame(frame_info_o, fexp);
      end
    end
    // out-of-range leading character, then address clear
    gap <= 1'b0;
    bad <= 1'b1;
    hgrp <= 32'h0;
    send <= 1'b1;
    @(posedge ref_clk_i);
    {send, bad} <= 2'b00;
    wait_hi(dec_char_err_o);
    chk_val(dec_char_err_o, 1);
    repeat (12) @(posedge ref_clk_i);
    dec_addr_clear_i <= 1'b1;
    @(posedge ref_clk_i);
    dec_addr_clear_i <= 1'b0;
    check_dec(32'hA5C3_0F96, 16'h0000);
    summarize();
  end
endmodule : tb
`default_nettype wire
